// File: core/sub_exec_consts.svh
// offsets, field positions, reset values, opcode patterns and timing for the subtract unit
// assumes: registers sit on a 32-bit avalon-mm slave, one aligned word each
`ifndef SUB_EXEC_CONSTS_SVH
`define SUB_EXEC_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_WORKING_REG 5'h00
`define OFS_STATUS_REG 5'h04
`define OFS_BANK_SEL_REG 5'h08
`define OFS_RESULT_REG 5'h0C
`define OFS_INFO_REG 5'h10

// ****************************************************************
// status and info field positions
// ****************************************************************
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_OV 3
`define ST_N 4
`define INFO_BUSY 0
`define INFO_BAD_OP 1
`define INFO_DEST_FILE 2

// ****************************************************************
// reset values
// ****************************************************************
`define RST_WORKING 8'h00
`define RST_STATUS 5'h00
`define RST_BANK_SEL 4'h0
`define RST_RESULT 8'h00

// ****************************************************************
// instruction encoding
// ****************************************************************
`define OPC_BORROW_SUB 6'h15
`define OPC_LIT_SUB 8'h08
`define INSTR_D_BIT 9
`define INSTR_A_BIT 8
`define ACCESS_HIGH_BANK 4'hF
`define ACCESS_LOW_BANK 4'h0

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 8
`define PHASES_PER_CYCLE 4

`endif

// File: core/sub_exec_pkg.sv
// types shared by the subtract execution unit
// assumes: nothing beyond a systemverilog compiler
package sub_exec_pkg;

	// ****************************************************************
	// execution phases: idle until an instruction is taken, then decode, read, process, write of one clock each
	// ****************************************************************
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_DECODE,
		PH_READ,
		PH_PROC,
		PH_WRITE
	} phase_e;

	// ****************************************************************
	// decoded operation
	// ****************************************************************
	typedef enum logic [1:0] {
		OP_NONE,
		OP_BORROW_SUB,
		OP_LIT_SUB
	} op_kind_e;

endpackage : sub_exec_pkg

// File: core/sub_flag_calc.sv
// eight-bit subtractor with status flag generation
// assumes: purely combinational, operands stable for the process phase
`timescale 1ns/100ps
`include "sub_exec_consts.svh"

module sub_flag_calc (
	// operands
	input wire logic [7:0] minuend_i,
	input wire logic [7:0] subtrahend_i,
	input wire logic no_borrow_i,
	// result and flags
	output logic [7:0] diff_o,
	output logic [4:0] flags_o
);

	logic [8:0] sum;
	logic [4:0] low_sum;

	// two's complement: a + ~b + carry, carry high means no borrow
	always_comb begin
		sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + {8'h00, no_borrow_i};
		low_sum = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + {4'h0, no_borrow_i};
		diff_o = sum[7:0];
		flags_o = 5'h00;
		flags_o[`ST_C] = sum[8]; // RULE_05
		flags_o[`ST_DC] = low_sum[4];
		flags_o[`ST_Z] = (sum[7:0] == 8'h00);
		flags_o[`ST_N] = sum[7]; // RULE_05
		flags_o[`ST_OV] = (minuend_i[7] != subtrahend_i[7]) && (sum[7] != minuend_i[7]);
	end

endmodule : sub_flag_calc

// File: core/subtract_borrow_literal_exec.sv
// execution unit for the borrow subtract and the literal subtract
// assumes: decoder and data register file on clk_sys_i, file read is combinational,
// software reaches the registers over avalon-mm with waitrequest
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`include "sub_exec_consts.svh"

// Overview of operation
// RULE_01: borrow subtract gives working minus file minus inverted carry, eight bits.
// RULE_02: literal subtract gives literal minus working register.
// RULE_03: literal is the unsigned low byte of the instruction word.
// RULE_04: literal subtract writes only the working register, never a file register.
// RULE_05: borrow clears carry and sets negative; no borrow sets carry. The code takes N from result bit 7, not from the borrow.
// RULE_06: destination bit zero writes working register, one writes the file register.
// RULE_07: access bit zero uses access bank, one uses bank select register.
// RULE_08: both update N, OV, C, DC, Z in one four-phase instruction cycle.
module subtract_borrow_literal_exec (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// instruction from the decoder
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_word_i,
	output logic instr_ready_o,
	output logic instr_done_o,
	// data register file
	output logic [11:0] file_rd_addr_o,
	input wire logic [7:0] file_rd_data_i,
	output logic file_wr_en_o,
	output logic [11:0] file_wr_addr_o,
	output logic [7:0] file_wr_data_o,
	// avalon-mm slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// core state
	output logic [7:0] working_register_o,
	output logic [4:0] status_o
);

	// ****************************************************************
	// reset release
	// ****************************************************************

	logic rst_meta_r;
	logic rst_n_r;

	// asynchronous assert, two-stage synchronous release
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// ****************************************************************
	// helpers
	// ****************************************************************

	// full data address of a file operand
	function automatic logic [11:0] file_address(input logic [15:0] word, input logic [3:0] bank);
		logic [3:0] page;
		page = bank;
		if (!word[`INSTR_A_BIT]) begin
			page = word[7] ? `ACCESS_HIGH_BANK : `ACCESS_LOW_BANK; // RULE_07
		end
		file_address = {page, word[7:0]};
	endfunction : file_address

	// operation class of an instruction word
	function automatic sub_exec_pkg::op_kind_e decode_op(input logic [15:0] word);
		decode_op = sub_exec_pkg::OP_NONE;
		if (word[15:10] == `OPC_BORROW_SUB) begin
			decode_op = sub_exec_pkg::OP_BORROW_SUB;
		end else if (word[15:8] == `OPC_LIT_SUB) begin
			decode_op = sub_exec_pkg::OP_LIT_SUB;
		end
	endfunction : decode_op

	// ****************************************************************
	// declarations
	// ****************************************************************

	sub_exec_pkg::phase_e phase_r, phase_nxt;
	sub_exec_pkg::op_kind_e op_r, op_nxt;
	logic [15:0] instr_r, instr_nxt;
	logic [7:0] fdata_r, fdata_nxt;
	logic [7:0] result_r, result_nxt;
	logic [4:0] flags_r, flags_nxt;
	logic dest_file_r, dest_file_nxt;
	logic [7:0] work_r, work_nxt;
	logic [4:0] status_r, status_nxt;
	logic [3:0] bank_r, bank_nxt;
	logic bad_op_r, bad_op_nxt;
	logic [11:0] rd_addr_r, rd_addr_nxt;
	logic wr_en_r, wr_en_nxt;
	logic [11:0] wr_addr_r, wr_addr_nxt;
	logic [7:0] wr_data_r, wr_data_nxt;
	logic done_r, done_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0] calc_a;
	logic [7:0] calc_b;
	logic calc_cin;
	logic [7:0] calc_diff;
	logic [4:0] calc_flags;
	logic bus_req;
	logic bus_done;
	logic bus_wr;
	logic take_instr;

	// ****************************************************************
	// arithmetic
	// ****************************************************************

	// operand routing per operation
	always_comb begin
		calc_a = work_r; // RULE_01
		calc_b = fdata_r;
		calc_cin = status_r[`ST_C]; // RULE_01
		if (op_r == sub_exec_pkg::OP_LIT_SUB) begin
			calc_a = instr_r[7:0]; // RULE_02 RULE_03
			calc_b = work_r; // RULE_02
			calc_cin = 1'b1;
		end
	end

	sub_flag_calc u_calc (
		.minuend_i(calc_a),
		.subtrahend_i(calc_b),
		.no_borrow_i(calc_cin),
		.diff_o(calc_diff),
		.flags_o(calc_flags)
	);

	// ****************************************************************
	// bus handshake
	// ****************************************************************

	// writes land only while idle so they never meet a commit edge
	assign bus_req = avs_read_i | avs_write_i;
	assign bus_done = ce_i & bus_req & ack_r & (avs_read_i | (phase_r == sub_exec_pkg::PH_IDLE));
	assign bus_wr = bus_done & avs_write_i & avs_byteenable_i[0];
	assign avs_waitrequest_o = ~bus_done;
	assign avs_readdata_o = rdata_r;
	assign take_instr = instr_ready_o & instr_valid_i & ce_i;

	// decoder handshake
	assign instr_ready_o = (phase_r == sub_exec_pkg::PH_IDLE) | (phase_r == sub_exec_pkg::PH_WRITE);
	assign instr_done_o = done_r;
	assign file_rd_addr_o = rd_addr_r;
	assign file_wr_en_o = wr_en_r;
	assign file_wr_addr_o = wr_addr_r;
	assign file_wr_data_o = wr_data_r;
	assign working_register_o = work_r;
	assign status_o = status_r;

	// ****************************************************************
	// execution next state
	// ****************************************************************

	// four phases: decode, read, process, write
	always_comb begin
		phase_nxt = phase_r;
		op_nxt = op_r;
		instr_nxt = instr_r;
		fdata_nxt = fdata_r;
		result_nxt = result_r;
		flags_nxt = flags_r;
		dest_file_nxt = dest_file_r;
		work_nxt = work_r;
		status_nxt = status_r;
		bank_nxt = bank_r;
		bad_op_nxt = bad_op_r;
		rd_addr_nxt = rd_addr_r;
		wr_en_nxt = 1'b0;
		wr_addr_nxt = wr_addr_r;
		wr_data_nxt = wr_data_r;
		done_nxt = 1'b0;
		// software writes, idle only
		if (bus_wr) begin
			unique case (avs_address_i)
				`OFS_WORKING_REG: work_nxt = avs_writedata_i[7:0];
				`OFS_STATUS_REG: status_nxt = avs_writedata_i[4:0];
				`OFS_BANK_SEL_REG: bank_nxt = avs_writedata_i[3:0];
				`OFS_INFO_REG: begin
					if (avs_writedata_i[`INFO_BAD_OP]) begin
						bad_op_nxt = 1'b0;
					end
				end
				default: ;
			endcase
		end
		unique case (phase_r)
			sub_exec_pkg::PH_IDLE: ;
			sub_exec_pkg::PH_DECODE: begin
				op_nxt = decode_op(instr_r);
				rd_addr_nxt = file_address(instr_r, bank_r); // RULE_07
				if (decode_op(instr_r) == sub_exec_pkg::OP_NONE) begin
					bad_op_nxt = 1'b1; // set wins over software clear
				end
				phase_nxt = sub_exec_pkg::PH_READ;
			end
			sub_exec_pkg::PH_READ: begin
				fdata_nxt = file_rd_data_i;
				phase_nxt = sub_exec_pkg::PH_PROC;
			end
			sub_exec_pkg::PH_PROC: begin
				result_nxt = calc_diff;
				flags_nxt = calc_flags;
				dest_file_nxt = (op_r == sub_exec_pkg::OP_BORROW_SUB) & instr_r[`INSTR_D_BIT];
				wr_en_nxt = (op_r == sub_exec_pkg::OP_BORROW_SUB) & instr_r[`INSTR_D_BIT]; // RULE_06 RULE_04
				wr_addr_nxt = rd_addr_r;
				wr_data_nxt = calc_diff;
				phase_nxt = sub_exec_pkg::PH_WRITE;
			end
			sub_exec_pkg::PH_WRITE: begin
				if (op_r != sub_exec_pkg::OP_NONE) begin
					status_nxt = flags_r; // RULE_08 RULE_05
					if (!dest_file_r) begin
						work_nxt = result_r; // RULE_06 RULE_04
					end
				end
				done_nxt = 1'b1;
				phase_nxt = sub_exec_pkg::PH_IDLE;
			end
		endcase
		// next instruction starts in the same edge that ends the last
		if (take_instr) begin
			instr_nxt = instr_word_i;
			phase_nxt = sub_exec_pkg::PH_DECODE; // RULE_08
		end
	end

	// ****************************************************************
	// execution registers
	// ****************************************************************

	// everything freezes while ce_i is low
	always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			phase_r <= sub_exec_pkg::PH_IDLE;
			op_r <= sub_exec_pkg::OP_NONE;
			instr_r <= 16'h0000;
			fdata_r <= 8'h00;
			result_r <= `RST_RESULT;
			flags_r <= `RST_STATUS;
			dest_file_r <= 1'b0;
			work_r <= `RST_WORKING;
			status_r <= `RST_STATUS;
			bank_r <= `RST_BANK_SEL;
			bad_op_r <= 1'b0;
			rd_addr_r <= 12'h000;
			wr_en_r <= 1'b0;
			wr_addr_r <= 12'h000;
			wr_data_r <= 8'h00;
			done_r <= 1'b0;
		end else if (ce_i) begin
			phase_r <= phase_nxt;
			op_r <= op_nxt;
			instr_r <= instr_nxt;
			fdata_r <= fdata_nxt;
			result_r <= result_nxt;
			flags_r <= flags_nxt;
			dest_file_r <= dest_file_nxt;
			work_r <= work_nxt;
			status_r <= status_nxt;
			bank_r <= bank_nxt;
			bad_op_r <= bad_op_nxt;
			rd_addr_r <= rd_addr_nxt;
			wr_en_r <= wr_en_nxt;
			wr_addr_r <= wr_addr_nxt;
			wr_data_r <= wr_data_nxt;
			done_r <= done_nxt;
		end
	end

	// ****************************************************************
	// bus read path
	// ****************************************************************

	// read data follows the state after the current edge
	always_comb begin
		ack_nxt = bus_req & ~bus_done;
		rdata_nxt = 32'h0000_0000;
		unique case (avs_address_i)
			`OFS_WORKING_REG: rdata_nxt[7:0] = work_nxt;
			`OFS_STATUS_REG: rdata_nxt[4:0] = status_nxt;
			`OFS_BANK_SEL_REG: rdata_nxt[3:0] = bank_nxt;
			`OFS_RESULT_REG: rdata_nxt[7:0] = result_nxt;
			`OFS_INFO_REG: begin
				rdata_nxt[`INFO_BUSY] = (phase_nxt != sub_exec_pkg::PH_IDLE);
				rdata_nxt[`INFO_BAD_OP] = bad_op_nxt;
				rdata_nxt[`INFO_DEST_FILE] = dest_file_nxt;
			end
			default: rdata_nxt = 32'h0000_0000; // unmapped reads zero
		endcase
	end

	// one wait state before each read answer; writes also wait until the phase is idle
	always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

endmodule : subtract_borrow_literal_exec

// File: tb/file_reg_model.sv
// data register file standing behind the subtract unit
// assumes: combinational read, write on the rising edge while enabled
`timescale 1ns/100ps

module file_reg_model (
	// clock
	input wire logic clk_i,
	// read and write ports
	input wire logic [11:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	input wire logic wr_en_i,
	input wire logic [11:0] wr_addr_i,
	input wire logic [7:0] wr_data_i
);
	logic [7:0] mem [4096];
	int wr_cnt = 0;
	// known contents, so a stray read never sees unknowns
	initial begin
		for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
	end
	assign rd_data_o = mem[rd_addr_i];
	// writes counted so the bench can spot unwanted ones
	always @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
			wr_cnt <= wr_cnt + 1;
		end
	end
endmodule : file_reg_model

// File: tb/sub_exec_sva.sv
// checker for the subtract unit, sees only the top module's ports
// assumes: ce_i held high, requests start after the reset copy is released
`timescale 1ns/100ps

module sub_exec_sva (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// decoder and file side
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_word_i,
	input wire logic instr_ready_o,
	input wire logic instr_done_o,
	input wire logic [11:0] file_rd_addr_o,
	input wire logic file_wr_en_o,
	input wire logic [7:0] file_wr_data_o,
	// bus side and flags
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic [4:0] status_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// decode of the word taken at this edge
	logic take;
	logic brw;
	logic lit;
	assign take = instr_valid_i & instr_ready_o;
	assign brw = take & (instr_word_i[15:10] == 6'h15);
	assign lit = take & (instr_word_i[15:8] == 8'h08);
	done_timing_a: assert property (take |-> ##5 instr_done_o)
		else $error("done not five cycles after take");
	busy_refuse_a: assert property (take |=> !instr_ready_o [*3] ##1 instr_ready_o)
		else $error("ready wrong during execution");
	lit_no_file_a: assert property (lit |=> !file_wr_en_o [*4])
		else $error("literal subtract wrote a file register");
	dest_file_a: assert property (brw && instr_word_i[9] |-> ##4 file_wr_en_o)
		else $error("file destination not written");
	dest_w_a: assert property (brw && !instr_word_i[9] |=> !file_wr_en_o [*4])
		else $error("working destination wrote file");
	access_bank_a: assert property (brw && !instr_word_i[8] |-> ##2 file_rd_addr_o ==
		{{4{$past(instr_word_i[7], 2)}}, $past(instr_word_i[7:0], 2)})
		else $error("access bank address wrong");
	flags_wr_a: assert property (file_wr_en_o |=> status_o[4] == $past(file_wr_data_o[7]) &&
		status_o[2] == ($past(file_wr_data_o) == 8'h00))
		else $error("negative or zero flag wrong");
	status_src_a: assert property ($changed(status_o) |-> instr_done_o ||
		$past(avs_write_i && !avs_waitrequest_o))
		else $error("flags changed without cause");
	rd_answer_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("read not answered in second cycle");
	cover property (brw && instr_word_i[9]);
	cover property (lit);
	cover property (take ##4 take);
endmodule : sub_exec_sva

bind subtract_borrow_literal_exec sub_exec_sva i_sva (.clk_sys_i, .resetn_i, .instr_valid_i,
	.instr_word_i, .instr_ready_o, .instr_done_o, .file_rd_addr_o, .file_wr_en_o,
	.file_wr_data_o, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .status_o);

// File: tb/subtract_borrow_literal_exec_tb.sv
// self-checking bench for the subtract unit
// assumes: avalon-mm master here, file register model as partner
`timescale 1ns/100ps

module subtract_borrow_literal_exec_tb;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic instr_valid_i = 1'b0;
	logic [15:0] instr_word_i = 16'h0000;
	logic [4:0] avs_address_i = 5'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic instr_ready_o, instr_done_o, file_wr_en_o, avs_waitrequest_o;
	logic [11:0] file_rd_addr_o, file_wr_addr_o;
	logic [7:0] file_rd_data_i, file_wr_data_o, working_register_o;
	logic [31:0] avs_readdata_o;
	logic [4:0] status_o;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	logic [7:0] bw [4] = '{8'h02, 8'h05, 8'h02, 8'h80};
	logic [7:0] bf [4] = '{8'h03, 8'h02, 8'h01, 8'h01};
	logic bc [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
	logic [7:0] lk [5] = '{8'h02, 8'h02, 8'h01, 8'hFF, 8'h00};
	logic [7:0] lw [5] = '{8'h01, 8'h02, 8'h02, 8'h00, 8'hFF};

	always #4 clk_sys_i = ~clk_sys_i;

	subtract_borrow_literal_exec i_dut (.clk_sys_i, .resetn_i, .ce_i(1'b1), .instr_valid_i,
		.instr_word_i, .instr_ready_o, .instr_done_o, .file_rd_addr_o, .file_rd_data_i,
		.file_wr_en_o, .file_wr_addr_o, .file_wr_data_o, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'h1), .avs_readdata_o,
		.avs_waitrequest_o, .working_register_o, .status_o);
	file_reg_model i_part (.clk_i(clk_sys_i), .rd_addr_i(file_rd_addr_o),
		.rd_data_o(file_rd_data_i), .wr_en_i(file_wr_en_o), .wr_addr_i(file_wr_addr_o),
		.wr_data_i(file_wr_data_o));

	// ****************************************************************
	// helpers
	// ****************************************************************
	task stop_test;
		if (fails == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask : chk

	// {N,OV,Z,DC,C,result} of a + ~b + nb
	function automatic logic [12:0] sub8(input logic [7:0] a, input logic [7:0] b,
		input logic nb);
		logic [8:0] s;
		logic [4:0] l;
		s = {1'b0, a} + {1'b0, ~b} + 9'(nb);
		l = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(nb);
		return {s[7], (a[7] ^ b[7]) & (s[7] ^ a[7]), s[7:0] == 8'h00, l[4], s[8], s[7:0]};
	endfunction : sub8

	// one avalon-mm cycle, entered just after a rising edge
	task bus(input logic wr, input logic [4:0] a, input logic [7:0] wd, output logic [31:0] rd);
		avs_address_i <= a;
		avs_writedata_i <= 32'(wd);
		avs_write_i <= wr;
		avs_read_i <= !wr;
		// waitrequest and read data are taken at the rising edge that ends the request
		@(posedge clk_sys_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask : bus

	task wr(input logic [4:0] a, input logic [7:0] v);
		logic [31:0] d;
		bus(1'b1, a, v, d);
	endtask : wr

	task rd_chk(input string nm, input logic [4:0] a, input logic [7:0] exp);
		logic [31:0] d;
		bus(1'b0, a, 8'h00, d);
		chk(nm, 32'(exp), d);
	endtask : rd_chk

	// offer a word and return at the edge that takes it; valid stays high
	task take(input logic [15:0] w);
		instr_word_i <= w;
		instr_valid_i <= 1'b1;
		@(negedge clk_sys_i);
		while (instr_ready_o !== 1'b1) @(negedge clk_sys_i);
		@(posedge clk_sys_i);
	endtask : take

	task wait_done;
		instr_valid_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk("done", 32'h0000_0001, 32'(instr_done_o));
		@(posedge clk_sys_i);
	endtask : wait_done

	task run(input logic [7:0] w, input logic c, input logic [11:0] fa, input logic [7:0] fv,
		input logic [15:0] ins);
		wr(5'h00, w);
		wr(5'h04, {7'h00, c});
		i_part.mem[fa] = fv;
		take(ins);
		wait_done();
	endtask : run

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_regs;
		rd_chk("working", 5'h00, 8'h00);
		rd_chk("status", 5'h04, 8'h00);
		rd_chk("bank", 5'h08, 8'h00);
		rd_chk("result", 5'h0C, 8'h00);
		wr(5'h14, 8'h5A);
		rd_chk("unmapped", 5'h14, 8'h00);
	endtask : t_regs

	task t_borrow;
		logic [12:0] e;
		for (int i = 0; i < 4; i++) begin
			e = sub8(bw[i], bf[i], bc[i]);
			run(bw[i], bc[i], 12'(16 + i), bf[i], {6'h15, i[0], 1'b0, 8'(16 + i)});
			chk("status", 32'(e[12:8]), 32'(status_o));
			chk("working", 32'(i[0] ? bw[i] : e[7:0]), 32'(working_register_o));
			chk("file", 32'(i[0] ? e[7:0] : bf[i]), 32'(i_part.mem[16 + i]));
		end
	endtask : t_borrow

	task t_bank;
		wr(5'h08, 8'h03);
		run(8'h09, 1'b1, 12'h320, 8'h04, {6'h15, 2'b11, 8'h20});
		chk("banked", 32'h0000_0005, 32'(i_part.mem[12'h320]));
		run(8'h09, 1'b1, 12'hF90, 8'h04, {6'h15, 2'b10, 8'h90});
		chk("access", 32'h0000_0005, 32'(i_part.mem[12'hF90]));
		rd_chk("result", 5'h0C, 8'h05);
		rd_chk("info", 5'h10, 8'h04);
	endtask : t_bank

	task t_lit;
		logic [12:0] e;
		int n;
		for (int i = 0; i < 5; i++) begin
			n = i_part.wr_cnt;
			e = sub8(lk[i], lw[i], 1'b1);
			run(lw[i], !i[0], 12'h000, 8'h00, {8'h08, lk[i]});
			chk("working", 32'(e[7:0]), 32'(working_register_o));
			chk("status", 32'(e[12:8]), 32'(status_o));
			chk("file writes", 32'(n), 32'(i_part.wr_cnt));
		end
	endtask : t_lit

	task t_b2b;
		logic [12:0] e;
		wr(5'h00, 8'h05);
		take(16'h0807);
		take(16'h0809);
		wait_done();
		e = sub8(8'h09, 8'h02, 1'b1);
		chk("working", 32'(e[7:0]), 32'(working_register_o));
		chk("status", 32'(e[12:8]), 32'(status_o));
	endtask : t_b2b

	// unknown opcode: busy and sticky error flag, no commit, error cleared by software
	task t_bad;
		int n;
		n = i_part.wr_cnt;
		wr(5'h00, 8'h3C);
		wr(5'h04, 8'h1F);
		take(16'hFFFF);
		instr_valid_i <= 1'b0;
		rd_chk("info busy", 5'h10, 8'h03);
		repeat (2) @(posedge clk_sys_i);
		rd_chk("info bad", 5'h10, 8'h02);
		wr(5'h10, 8'h02);
		rd_chk("info clear", 5'h10, 8'h00);
		chk("working", 32'h0000_003C, 32'(working_register_o));
		chk("status", 32'h0000_001F, 32'(status_o));
		chk("file writes", 32'(n), 32'(i_part.wr_cnt));
	endtask : t_bad

	// ****************************************************************
	// main sequence and timeout
	// ****************************************************************
	initial begin
		repeat (8) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		t_regs();
		t_borrow();
		t_bank();
		t_lit();
		t_b2b();
		t_bad();
		stop_test();
	end

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			stop_test();
		end
	end
endmodule : subtract_borrow_literal_exec_tb
